// >>> core/ecp_pkg.sv
// Package with register map, field layout and carrier types of the pin assign block
package ecp_pkg;

	// Register byte address and reset value
	localparam logic [11:0] ECP_ADDR_ASSIGN = 12'h000;
	localparam logic [11:0] ECP_ADDR_SECOND = 12'h004;
	localparam logic [31:0] ECP_RESET_VAL   = 32'h0000_0000;
	localparam logic [31:0] ECP_DEFINED_MSK = 32'hfffc_003f;
	localparam logic [31:0] ECP_SECOND_MSK  = 32'h0000_000f;

	// Field positions in the assignment register
	localparam int ECP_B_CEC1      = 31;
	localparam int ECP_B_CEC0      = 30;
	localparam int ECP_B_SPLC_HI   = 29;
	localparam int ECP_B_SPLC_LO   = 28;
	localparam int ECP_B_PPS       = 27;
	localparam int ECP_B_COUT      = 26;
	localparam int ECP_B_MD1       = 25;
	localparam int ECP_B_MD0       = 24;
	localparam int ECP_B_MC1       = 23;
	localparam int ECP_B_MC0       = 22;
	localparam int ECP_B_TE1       = 21;
	localparam int ECP_B_TE0       = 20;
	localparam int ECP_B_TD1       = 19;
	localparam int ECP_B_TD0       = 18;
	localparam int ECP_B_ZIN_LO    = 4;
	localparam int ECP_B_BIN_LO    = 2;
	localparam int ECP_B_AIN_LO    = 0;

	// Fields of the secondary register (alternate CEC selects)
	localparam int ECP_B_CECR0_LO  = 0;
	localparam int ECP_B_CECR1_LO  = 2;

	// Standby input keep encodings
	localparam logic [1:0] ECP_KEEP_NONE = 2'h0;
	localparam logic [1:0] ECP_KEEP_MII0 = 2'h1;
	localparam logic [1:0] ECP_KEEP_RMII0 = 2'h2;
	localparam logic [1:0] ECP_KEEP_RMII1 = 2'h3;

	// Pin option one-hot codes for a two bit input select
	localparam logic [2:0] ECP_OPT0 = 3'h1;
	localparam logic [2:0] ECP_OPT1 = 3'h2;
	localparam logic [2:0] ECP_OPT2 = 3'h4;

	// Ethernet output enables to the pad ring
	typedef struct packed {
		logic pps;
		logic clk_out;
		logic mgmt_data1;
		logic mgmt_data0;
		logic mgmt_clock1;
		logic mgmt_clock0;
		logic txerr0_txen1;
		logic txen0;
		logic txd_upper;
		logic txd_lower;
	} ecp_eth_oe_t;

	// Standby input keep flags
	typedef struct packed {
		logic mii0;
		logic rmii0;
		logic rmii1;
	} ecp_keep_t;

endpackage

// >>> core/ecp_pin_assign.sv
// Pin function assignment register for Ethernet, CEC and position counter pins
//
// Overview of operation
// - All defined fields clear to zero at reset
// - Reads return last written field values
// - Bit 31 connects CEC channel 1 pin
// - Bit 30 connects CEC channel 0 pin
// - Other variants use secondary two-bit CEC selects
// - Bits 29:28 pick inputs kept live in standby
// - Bit 27 enables pulse-per-second pin output
// - Bit 26 enables Ethernet clock-out pin output
// - Bit 25 enables mgmt data 1; input stays
// - Bit 24 enables mgmt data 0; input stays
// - Bit 23 enables mgmt clock 1; tx clock in stays
// - Bit 22 enables mgmt clock 0 output
// - Bit 21 enables shared txerr0/txen1 output
// - Bits 20..18 enable txen0, upper, lower data
// - Position input selects: 00/01 opt0, 10 opt1, 11 opt2
// - Reserved bits 17:6 read zero, writes ignored
// - Contents survive deep standby transition reset
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module ecp_pin_assign
	import ecp_pkg::*;
#(
	parameter bit VARIANT_CEC_LOCAL = 1'b1 // Variant six or seven
) (
	input  wire logic              I_CLK_SYS,
	input  wire logic              I_SRST,
	input  wire logic              i_deep_standby_rst,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [11:0]       i_paddr,
	input  wire logic [31:0]       i_pwdata,
	input  wire logic [3:0]        i_pstrb,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	input  wire logic              i_eth_pps,
	input  wire logic              i_eth_clk_out,
	input  wire logic              i_eth_mgmt_data1_out,
	input  wire logic              i_eth_mgmt_data0_out,
	input  wire logic              i_eth_mgmt_clock1_out,
	input  wire logic              i_eth_mgmt_clock0_out,
	input  wire logic              i_eth_txerr0_txen1,
	input  wire logic              i_eth_txen0,
	input  wire logic [1:0]        i_eth_txd_upper,
	input  wire logic [1:0]        i_eth_txd_lower,
	output ecp_eth_oe_t            o_eth_oe,
	output logic                   o_eth_pps_pin,
	output logic                   o_eth_clk_out_pin,
	output logic                   o_eth_mdio1_pin,
	output logic                   o_eth_mdio0_pin,
	output logic                   o_eth_mdc1_pin,
	output logic                   o_eth_mdc0_pin,
	output logic                   o_eth_txerr0_txen1_pin,
	output logic                   o_eth_txen0_pin,
	output logic      [1:0]        o_eth_txd_upper_pin,
	output logic      [1:0]        o_eth_txd_lower_pin,
	output ecp_keep_t              o_eth_standby_keep,
	output logic                   o_cec1_connect,
	output logic                   o_cec0_connect,
	output logic                   o_mgmt_data_in_connect,
	output logic                   o_tx_clock0_in_connect,
	input  wire logic [2:0]        i_pos2_index_pins,
	input  wire logic [2:0]        i_pos2_phase_b_pins,
	input  wire logic [2:0]        i_pos2_phase_a_pins,
	output logic                   o_pos2_index,
	output logic                   o_pos2_phase_b,
	output logic                   o_pos2_phase_a,
	output logic      [2:0]        o_pos2_sel_onehot
);

	// Bus side register state and next values
	logic [31:0] assign_q;
	logic [31:0] assign_d;
	logic [31:0] second_q;
	logic [31:0] second_d;
	logic [31:0] rdata_d;
	logic [31:0] wmask;
	logic        wr_en;
	logic        rd_setup;
	logic        hit_assign;
	logic        hit_second;
	logic        hit_any;
	logic [1:0]  cecr1;
	logic [1:0]  cecr0;

	// Position counter input path
	logic [2:0]  pos_raw    [3];
	logic [2:0]  pos_meta_q [3];
	logic [2:0]  pos_sync_q [3];
	logic [2:0]  pos_sel    [3];
	logic [2:0]  pos_hit    [3];
	logic [2:0]  pos_out;
	genvar       g;

	// Decode a two bit input select to a one-hot pin option
	function automatic logic [2:0] pos_decode(input logic [1:0] s);
		case (s)
			2'h2:    pos_decode = ECP_OPT1;
			2'h3:    pos_decode = ECP_OPT2;
			default: pos_decode = ECP_OPT0;
		endcase
	endfunction

	// Merge write data into a register word by byte lane
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_word,
		input logic [31:0] new_word,
		input logic [31:0] lane_mask,
		input logic [31:0] keep_mask
	);
		lane_merge = (old_word & ~lane_mask) |
			(new_word & lane_mask & keep_mask);
	endfunction

	// Address decode and access phase qualifiers
	assign hit_assign = (i_paddr == ECP_ADDR_ASSIGN);
	assign hit_second = (i_paddr == ECP_ADDR_SECOND);
	assign hit_any    = hit_assign | hit_second;
	assign wr_en      = i_psel & i_penable & i_pwrite;
	assign rd_setup   = i_psel & ~i_penable & ~i_pwrite;

	// Byte lane write mask, one strobe for each eight data bits
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			assign wmask[8*g +: 8] = {8{i_pstrb[g]}};
		end
	endgenerate

	// Single cycle access phase, unmapped addresses flag an error
	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~hit_any;

	// Next assignment word, only defined bits are ever stored
	always_comb begin
		assign_d = assign_q;
		if (wr_en && hit_assign) begin
			assign_d = lane_merge(assign_q, i_pwdata, wmask,
				ECP_DEFINED_MSK);
		end
	end

	// Assignment register; deep standby reset is not a clear source
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			assign_q <= ECP_RESET_VAL;
		end else begin
			assign_q <= assign_d;
		end
	end

	// Next secondary word holding the alternate CEC selects
	always_comb begin
		second_d = second_q;
		if (wr_en && hit_second) begin
			second_d = lane_merge(second_q, i_pwdata, wmask,
				ECP_SECOND_MSK);
		end
	end

	// Secondary register, cleared with the assignment register
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			second_q <= ECP_RESET_VAL;
		end else begin
			second_q <= second_d;
		end
	end

	// Read word chosen in the setup phase, unmapped reads give zero
	always_comb begin
		rdata_d = o_prdata;
		if (rd_setup) begin
			if (hit_assign) begin
				rdata_d = assign_q & ECP_DEFINED_MSK;
			end else if (hit_second) begin
				rdata_d = second_q & ECP_SECOND_MSK;
			end else begin
				rdata_d = ECP_RESET_VAL;
			end
		end
	end

	// Read data register holds until the next read setup
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			o_prdata <= ECP_RESET_VAL;
		end else begin
			o_prdata <= rdata_d;
		end
	end

	// Output enables follow register bits directly
	always_comb begin
		o_eth_oe.pps          = assign_q[ECP_B_PPS];
		o_eth_oe.clk_out      = assign_q[ECP_B_COUT];
		o_eth_oe.mgmt_data1   = assign_q[ECP_B_MD1];
		o_eth_oe.mgmt_data0   = assign_q[ECP_B_MD0];
		o_eth_oe.mgmt_clock1  = assign_q[ECP_B_MC1];
		o_eth_oe.mgmt_clock0  = assign_q[ECP_B_MC0];
		o_eth_oe.txerr0_txen1 = assign_q[ECP_B_TE1];
		o_eth_oe.txen0        = assign_q[ECP_B_TE0];
		o_eth_oe.txd_upper    = assign_q[ECP_B_TD1];
		o_eth_oe.txd_lower    = assign_q[ECP_B_TD0];
	end

	// Timestamp pulse pin, gated so a disabled function drives nothing
	always_comb begin
		o_eth_pps_pin = i_eth_pps & o_eth_oe.pps;
	end

	// Clock-out pin
	always_comb begin
		o_eth_clk_out_pin = i_eth_clk_out & o_eth_oe.clk_out;
	end

	// Management data pin of channel 1
	always_comb begin
		o_eth_mdio1_pin = i_eth_mgmt_data1_out &
			o_eth_oe.mgmt_data1;
	end

	// Management data pin of channel 0
	always_comb begin
		o_eth_mdio0_pin = i_eth_mgmt_data0_out &
			o_eth_oe.mgmt_data0;
	end

	// Management clock pin of channel 1
	always_comb begin
		o_eth_mdc1_pin = i_eth_mgmt_clock1_out &
			o_eth_oe.mgmt_clock1;
	end

	// Management clock pin of channel 0
	always_comb begin
		o_eth_mdc0_pin = i_eth_mgmt_clock0_out &
			o_eth_oe.mgmt_clock0;
	end

	// Shared transmit error and enable pin
	always_comb begin
		o_eth_txerr0_txen1_pin = i_eth_txerr0_txen1 &
			o_eth_oe.txerr0_txen1;
	end

	// Transmit enable pin of channel 0
	always_comb begin
		o_eth_txen0_pin = i_eth_txen0 & o_eth_oe.txen0;
	end

	// Upper transmit data pair
	always_comb begin
		o_eth_txd_upper_pin = i_eth_txd_upper &
			{2{o_eth_oe.txd_upper}};
	end

	// Lower transmit data pair
	always_comb begin
		o_eth_txd_lower_pin = i_eth_txd_lower & {2{o_eth_oe.txd_lower}};
	end

	// Input paths that stay connected in every state
	assign o_mgmt_data_in_connect = 1'b1;
	assign o_tx_clock0_in_connect = 1'b1;

	// Standby keep flags from the two bit field
	function automatic ecp_keep_t keep_decode(input logic [1:0] s);
		keep_decode = '0;
		case (s)
			ECP_KEEP_MII0:  keep_decode.mii0  = 1'b1;
			ECP_KEEP_RMII0: keep_decode.rmii0 = 1'b1;
			ECP_KEEP_RMII1: keep_decode.rmii1 = 1'b1;
			default:        keep_decode = '0;
		endcase
	endfunction

	// Standby input keep decode
	assign o_eth_standby_keep = keep_decode(
		assign_q[ECP_B_SPLC_HI:ECP_B_SPLC_LO]);

	// Alternate CEC select fields of the secondary register
	assign cecr1 = second_q[ECP_B_CECR1_LO +: 2];
	assign cecr0 = second_q[ECP_B_CECR0_LO +: 2];

	// CEC pin connection, local bits or secondary selects by variant
	always_comb begin
		if (VARIANT_CEC_LOCAL) begin
			o_cec1_connect = assign_q[ECP_B_CEC1];
			o_cec0_connect = assign_q[ECP_B_CEC0];
		end else begin
			o_cec1_connect = (cecr1 != 2'h0);
			o_cec0_connect = (cecr0 != 2'h0);
		end
	end

	// Pin groups in the order phase A, phase B, index
	assign pos_raw[0] = i_pos2_phase_a_pins;
	assign pos_raw[1] = i_pos2_phase_b_pins;
	assign pos_raw[2] = i_pos2_index_pins;

	// First synchroniser stage, pins are asynchronous to the clock
	always_ff @(posedge I_CLK_SYS) begin
		for (int c = 0; c < 3; c++) begin
			if (I_SRST) begin
				pos_meta_q[c] <= 3'h0;
			end else begin
				pos_meta_q[c] <= pos_raw[c];
			end
		end
	end

	// Second stage, the only reader of the first
	always_ff @(posedge I_CLK_SYS) begin
		for (int c = 0; c < 3; c++) begin
			if (I_SRST) begin
				pos_sync_q[c] <= 3'h0;
			end else begin
				pos_sync_q[c] <= pos_meta_q[c];
			end
		end
	end

	// Select each position input from its chosen pin option
	generate
		for (g = 0; g < 3; g++) begin : g_pos
			assign pos_sel[g] = pos_decode(assign_q[2*g +: 2]);
			assign pos_hit[g] = pos_sync_q[g] & pos_sel[g];
			assign pos_out[g] = |pos_hit[g];
		end
	endgenerate

	// Selected position inputs to the counter
	assign o_pos2_phase_a = pos_out[0];
	assign o_pos2_phase_b = pos_out[1];
	assign o_pos2_index   = pos_out[2];

	// Phase A select reported as one-hot
	assign o_pos2_sel_onehot = pos_sel[0];

endmodule

// >>> verification/ecp_pin_assign_assertions.sv
// Checker of the pin assign register behaviour seen at the block ports
`timescale 1ns/100ps
module ecp_pin_assign_assertions
	import ecp_pkg::*;
(
	input wire logic        I_CLK_SYS,
	input wire logic        I_SRST,
	input wire logic        i_deep_standby_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0]  i_pstrb,
	input wire logic [31:0] o_prdata,
	input wire logic        i_eth_txen0,
	input wire ecp_eth_oe_t o_eth_oe,
	input wire logic        o_eth_txen0_pin,
	input wire ecp_keep_t   o_eth_standby_keep,
	input wire logic        o_cec1_connect,
	input wire logic        o_cec0_connect,
	input wire logic [2:0]  o_pos2_sel_onehot
);
	// Full word write to the assignment register completes
	wire wr_hit = i_psel & i_penable & i_pwrite & (i_pstrb == 4'hf)
		& (i_paddr == ECP_ADDR_ASSIGN);
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (I_SRST);
	property p_oe; wr_hit |=> o_eth_oe == $past(i_pwdata[27:18]); endproperty
	a_oe: assert property (p_oe) else $error("oe wrong");
	property p_rst; $fell(I_SRST) |-> o_eth_oe == '0; endproperty
	a_rst: assert property (p_rst) else $error("oe not cleared");
	property p_keep; wr_hit |=> o_eth_standby_keep == {$past(i_pwdata[29:28])
		== 2'h1, $past(i_pwdata[29:28]) == 2'h2, &$past(i_pwdata[29:28])};
	endproperty
	a_keep: assert property (p_keep) else $error("keep wrong");
	property p_cec; wr_hit |=> {o_cec1_connect, o_cec0_connect}
		== $past(i_pwdata[31:30]); endproperty
	a_cec: assert property (p_cec) else $error("cec wrong");
	property p_pos; wr_hit |=> o_pos2_sel_onehot == ($past(i_pwdata[1]) ?
		($past(i_pwdata[0]) ? ECP_OPT2 : ECP_OPT1) : ECP_OPT0); endproperty
	a_pos: assert property (p_pos) else $error("select wrong");
	property p_rsv; i_psel & i_penable & !i_pwrite & i_paddr == ECP_ADDR_ASSIGN
		|-> o_prdata[17:6] == '0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved set");
	property p_gate; o_eth_txen0_pin == (i_eth_txen0 & o_eth_oe.txen0);
	endproperty
	a_gate: assert property (p_gate) else $error("pin ungated");
	property p_deep; $rose(i_deep_standby_rst) && !wr_hit |=> $stable(o_eth_oe);
	endproperty
	a_deep: assert property (p_deep) else $error("deep reset hit");
endmodule

// >>> verification/ecp_pad_model.sv
// Pad ring and peripheral source model feeding the block's pin side
`timescale 1ns/100ps
module ecp_pad_model (
	input  wire logic        i_clk,
	input  wire logic        i_hold,
	input  wire logic [8:0]  i_pads,
	output logic      [11:0] o_eth_src,
	output logic      [8:0]  o_pads
);
	logic [11:0] cnt_q = 12'h000;
	// Peripheral levels change every cycle so a stale pin value shows
	always @(posedge i_clk) cnt_q <= cnt_q + 12'h5a7;
	assign o_eth_src = cnt_q;
	// Pads keep a commanded level, or wander when let go
	assign o_pads = i_hold ? i_pads : cnt_q[8:0] ^ 9'h1b5;
endmodule

// >>> verification/tb_ethernet_cec_pin_function_select.sv
// Self-checking bench of the pin assign register
`timescale 1ns/100ps
module tb_ethernet_cec_pin_function_select import ecp_pkg::*; ;
	logic clk = 0, rst = 1, deep = 0, psel = 0, pen = 0, pwr = 0, hold = 0;
	logic [11:0] addr = 0;
	logic [31:0] wd = 0, rd, rv;
	logic [8:0]  pads = 0, pad_w;
	logic [11:0] src;
	logic [2:0]  pos, soh;
	logic [11:0] pins;
	logic [1:0]  cec, incon;
	logic        rdy, err, ev;
	ecp_eth_oe_t oe;
	ecp_keep_t   keep;
	int          n_errors = 0, total_checks = 0;
	ecp_pad_model pad (.i_clk(clk), .i_hold(hold), .i_pads(pads),
		.o_eth_src(src), .o_pads(pad_w));
	ecp_pin_assign uut (.I_CLK_SYS(clk), .I_SRST(rst), .i_deep_standby_rst(deep),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
		.i_pwdata(wd), .i_pstrb(4'hf), .o_prdata(rd), .o_pready(rdy),
		.o_pslverr(err), .i_eth_pps(src[11]), .i_eth_clk_out(src[10]),
		.i_eth_mgmt_data1_out(src[9]), .i_eth_mgmt_data0_out(src[8]),
		.i_eth_mgmt_clock1_out(src[7]), .i_eth_mgmt_clock0_out(src[6]),
		.i_eth_txerr0_txen1(src[5]), .i_eth_txen0(src[4]),
		.i_eth_txd_upper(src[3:2]), .i_eth_txd_lower(src[1:0]), .o_eth_oe(oe),
		.o_eth_pps_pin(pins[11]), .o_eth_clk_out_pin(pins[10]),
		.o_eth_mdio1_pin(pins[9]), .o_eth_mdio0_pin(pins[8]),
		.o_eth_mdc1_pin(pins[7]), .o_eth_mdc0_pin(pins[6]),
		.o_eth_txerr0_txen1_pin(pins[5]), .o_eth_txen0_pin(pins[4]),
		.o_eth_txd_upper_pin(pins[3:2]), .o_eth_txd_lower_pin(pins[1:0]),
		.o_eth_standby_keep(keep), .o_cec1_connect(cec[1]),
		.o_cec0_connect(cec[0]), .o_mgmt_data_in_connect(incon[1]),
		.o_tx_clock0_in_connect(incon[0]),
		.i_pos2_index_pins(pad_w[8:6]), .i_pos2_phase_b_pins(pad_w[5:3]),
		.i_pos2_phase_a_pins(pad_w[2:0]), .o_pos2_index(pos[2]),
		.o_pos2_phase_b(pos[1]), .o_pos2_phase_a(pos[0]),
		.o_pos2_sel_onehot(soh));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (rdy !== 1'b1 && ++n < 20);
		rv = rd;
		ev = err;
		psel <= 0;
		pen <= 0;
		if (n >= 20) n_errors++;
		@(posedge clk);
	endtask
	task automatic t_rw;
		apb(0, ECP_ADDR_ASSIGN, 0);
		chk(0, rv);
		apb(1, ECP_ADDR_ASSIGN, 32'hffff_ffff);
		apb(0, ECP_ADDR_ASSIGN, 0);
		chk(ECP_DEFINED_MSK, rv);
		apb(0, 12'h008, 0);
		chk(1, {31'h0, ev});
		$display("read write test done");
	endtask
	task automatic t_fields;
		for (int i = 18; i < 28; i++) begin
			apb(1, ECP_ADDR_ASSIGN, 32'h1 << i);
			chk(32'h1 << (i - 18), {22'h0, oe});
		end
		for (int k = 0; k < 4; k++) begin
			apb(1, ECP_ADDR_ASSIGN, 32'(k) << 28);
			chk({29'h0, k == 1, k == 2, k == 3}, {29'h0, keep});
		end
		$display("field test done");
	endtask
	task automatic t_pins;
		apb(1, ECP_ADDR_ASSIGN, 32'hc000_0000);
		chk(32'h3, {30'h0, cec});
		chk(0, {20'h0, pins});
		chk(32'h3, {30'h0, incon});
		apb(1, ECP_ADDR_ASSIGN, 32'h0ffc_0000);
		chk(0, {30'h0, cec});
		repeat (3) begin
			@(posedge clk);
			chk({20'h0, src}, {20'h0, pins});
		end
		apb(1, ECP_ADDR_SECOND, 32'h5);
		apb(0, ECP_ADDR_SECOND, 0);
		chk(32'h5, rv);
		chk(0, {30'h0, cec});
		$display("pin test done");
	endtask
	task automatic t_pos;
		hold <= 1;
		for (int s = 0; s < 4; s++) begin
			logic [2:0] oh;
			oh = s == 3 ? 3'h4 : (s == 2 ? 3'h2 : 3'h1);
			apb(1, ECP_ADDR_ASSIGN, {26'h0, {3{2'(s)}}});
			chk({29'h0, oh}, {29'h0, soh});
			pads <= {oh, oh, oh};
			repeat (4) @(posedge clk);
			chk(3'h7, pos);
			pads <= ~{oh, oh, oh};
			repeat (4) @(posedge clk);
			chk(0, pos);
		end
		hold <= 0;
		$display("position select test done");
	endtask
	task automatic t_deep;
		apb(1, ECP_ADDR_ASSIGN, ECP_DEFINED_MSK);
		deep <= 1;
		repeat (3) @(posedge clk);
		deep <= 0;
		apb(0, ECP_ADDR_ASSIGN, 0);
		chk(ECP_DEFINED_MSK, rv);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		apb(0, ECP_ADDR_ASSIGN, 0);
		chk(0, rv);
		chk(0, {22'h0, oe});
		$display("reset test done");
	endtask
	task results;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		t_rw;
		t_fields;
		t_pins;
		t_pos;
		t_deep;
		results;
	end
	initial begin
		#400000;
		n_errors++;
		results;
	end
endmodule
bind ecp_pin_assign ecp_pin_assign_assertions u_chk (.*);
